// File: bench/system_options_power_monitor_regs_assertions.sv
`timescale 1ns/1ps
module sysopt_chk
   import sysopt_pkg::*;
#(parameter logic [11:0] PART_NUMBER = 12'h5c3) (
   input wire logic core_clk,
   input wire logic rst,
   input wire sysopt_pkg::apb_req_t apb_req,
   input wire sysopt_pkg::apb_rsp_t apb_rsp,
   input wire logic supply_below_warning,
   input wire logic supply_below_detect,
   input wire logic stop_mode,
   input wire logic service_write,
   input wire logic service_window_open,
   input wire logic analog_comparator_out,
   input wire logic timer_a_ch0_pin_in,
   input wire logic timer_a_ch0_capture_in,
   input wire sysopt_pkg::options_two_t options_two,
   input wire logic [2:0] watchdog_timeout_code,
   input wire logic watchdog_window_active,
   input wire logic supply_detect_active,
   input wire logic bandgap_buffer_enable,
   input wire logic supply_warning_irq,
   input wire logic chip_reset_req
);
   logic rd_acc;
   logic pc_wr;
   assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign pc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
      && apb_req.paddr == OFS_POWER_CTRL_ONE;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_window_gate: assert property (watchdog_window_active
      == (options_two.window_mode && options_two.clock_select)) else $error("window gate");
   a_reset_sticky: assert property (chip_reset_req |=> chip_reset_req)
      else $error("reset dropped");
   a_early_service: assert property (service_write && watchdog_window_active
      && !service_window_open |=> chip_reset_req) else $error("no reset");
   // Flag and enable clear only through a write to the control register
   a_irq_hold: assert property (supply_warning_irq && !pc_wr |=> supply_warning_irq)
      else $error("irq dropped");
   a_id_low: assert property (rd_acc && apb_req.paddr == OFS_PART_ID_LOW
      |-> apb_rsp.prdata == {24'h0, PART_NUMBER[7:0]}) else $error("id low");
   a_id_high: assert property (rd_acc && apb_req.paddr == OFS_PART_ID_HIGH
      |-> apb_rsp.prdata == {28'h0, PART_NUMBER[11:8]}) else $error("id high");
   a_cap_route: assert property (
      (options_two.cmp_route && $stable(analog_comparator_out))[*4]
      |-> timer_a_ch0_capture_in == analog_comparator_out) else $error("capture route");
   a_cap_pin: assert property (
      (!options_two.cmp_route && $stable(timer_a_ch0_pin_in))[*4]
      |-> timer_a_ch0_capture_in == timer_a_ch0_pin_in) else $error("capture pin");
endmodule
bind system_options_power_monitor_regs sysopt_chk #(.PART_NUMBER(PART_NUMBER)) u_chk (
   .core_clk, .rst, .apb_req, .apb_rsp, .supply_below_warning, .supply_below_detect,
   .stop_mode, .service_write, .service_window_open, .analog_comparator_out,
   .timer_a_ch0_pin_in, .timer_a_ch0_capture_in, .options_two, .watchdog_timeout_code,
   .watchdog_window_active, .supply_detect_active, .bandgap_buffer_enable,
   .supply_warning_irq, .chip_reset_req);

// File: bench/system_options_power_monitor_regs_bench.sv
`timescale 1ns/1ps
module system_options_power_monitor_regs_bench;
   import sysopt_pkg::*;
   localparam logic [11:0] PN = 12'h2b7; // Arbitrary
   logic core_clk = 1'b0, rst = 1'b1, stop_mode = 1'b0, service_write = 1'b0;
   logic supply_below_warning = 1'b0, supply_below_detect = 1'b0, service_window_open = 1'b0;
   logic analog_comparator_out = 1'b0, timer_a_ch0_pin_in = 1'b0, timer_a_ch0_capture_in;
   logic watchdog_window_active, supply_detect_active, bandgap_buffer_enable;
   logic supply_warning_irq, chip_reset_req, err;
   logic [2:0] watchdog_timeout_code;
   logic [31:0] rd;
   apb_req_t apb_req = '0;
   apb_rsp_t apb_rsp;
   options_two_t options_two;
   int n_mismatch = 0;
   int n_tests = 0;
   system_options_power_monitor_regs #(.PART_NUMBER(PN)) i_dut (
      .core_clk, .rst, .apb_req, .apb_rsp, .supply_below_warning, .supply_below_detect,
      .stop_mode, .service_write, .service_window_open, .analog_comparator_out,
      .timer_a_ch0_pin_in, .timer_a_ch0_capture_in, .options_two, .watchdog_timeout_code,
      .watchdog_window_active, .supply_detect_active, .bandgap_buffer_enable,
      .supply_warning_irq, .chip_reset_req);
   initial forever #20 core_clk = ~core_clk;
   task automatic summarize;
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Idle cycle after each transfer, so no signal is driven twice at one edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      i = 0;
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
         i++;
      end while (apb_rsp.pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_mismatch++;
         summarize();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask
   task automatic do_reset;
      rst <= 1'b1;
      cyc(20);
      rst <= 1'b0;
   endtask
   task automatic s_opts;
      xfer(OFS_OPTIONS_TWO, 1'b1, 32'hff);
      rchk(OFS_OPTIONS_TWO, 32'hdf);
      chk(32'(options_two), 32'h7f);
      chk(watchdog_window_active, 1'b1);
      analog_comparator_out <= 1'b1;
      cyc(4);
      chk(timer_a_ch0_capture_in, 1'b1);
      xfer(OFS_OPTIONS_TWO, 1'b1, 32'h00);
      rchk(OFS_OPTIONS_TWO, 32'hc0);
      chk(32'(options_two), 32'h60);
      chk(timer_a_ch0_capture_in, 1'b0);
      xfer(OFS_OPTIONS_ONE, 1'b1, 32'h00);
      xfer(OFS_OPTIONS_ONE, 1'b1, 32'hc0);
      chk(watchdog_timeout_code, 32'h4);
   endtask
   task automatic s_id;
      xfer(OFS_PART_ID_HIGH, 1'b1, 32'hff);
      rchk(OFS_PART_ID_HIGH, {28'h0, PN[11:8]});
      rchk(OFS_PART_ID_LOW, {24'h0, PN[7:0]});
      xfer(8'h14, 1'b0, 32'h0);
      chk(err, 1'b1);
   endtask
   task automatic s_warn;
      xfer(OFS_POWER_CTRL_ONE, 1'b1, 32'h3d);
      chk(bandgap_buffer_enable, 1'b1);
      supply_below_warning <= 1'b1;
      cyc(4);
      chk(supply_warning_irq, 1'b1);
      xfer(OFS_POWER_CTRL_ONE, 1'b1, 32'h7d);
      rchk(OFS_POWER_CTRL_ONE, 32'hbd);
      supply_below_warning <= 1'b0;
      cyc(4);
      rchk(OFS_POWER_CTRL_ONE, 32'hbd);
      xfer(OFS_POWER_CTRL_ONE, 1'b1, 32'h7d);
      rchk(OFS_POWER_CTRL_ONE, 32'h3d);
      chk(supply_warning_irq, 1'b0);
   endtask
   task automatic s_detect;
      stop_mode <= 1'b1;
      cyc(1);
      chk(supply_detect_active, 1'b1);
      supply_below_detect <= 1'b1;
      cyc(4);
      chk(chip_reset_req, 1'b1);
      supply_below_detect <= 1'b0;
      stop_mode <= 1'b0;
      supply_below_warning <= 1'b1;
      do_reset();
      cyc(4);
      rchk(OFS_POWER_CTRL_ONE, 32'h9c);
      chk(supply_warning_irq, 1'b0);
      supply_below_warning <= 1'b0;
      // Reset enable left on, so only the detect enable holds the reset back
      xfer(OFS_POWER_CTRL_ONE, 1'b1, 32'h10);
      chk(supply_detect_active, 1'b0);
      xfer(OFS_POWER_CTRL_ONE, 1'b1, 32'h1c);
      chk(supply_detect_active, 1'b0);
      supply_below_detect <= 1'b1;
      cyc(4);
      chk(chip_reset_req, 1'b0);
      supply_below_detect <= 1'b0;
   endtask
   task automatic s_window;
      do_reset();
      xfer(OFS_OPTIONS_TWO, 1'b1, 32'h40);
      chk(watchdog_window_active, 1'b0);
      chk(watchdog_timeout_code, 32'h3);
      do_reset();
      xfer(OFS_OPTIONS_TWO, 1'b1, 32'hc0);
      xfer(OFS_POWER_CTRL_ONE, 1'b1, 32'h04);
      stop_mode <= 1'b1;
      cyc(1);
      chk(supply_detect_active, 1'b0);
      stop_mode <= 1'b0;
      service_write <= 1'b1;
      service_window_open <= 1'b1;
      cyc(1);
      service_write <= 1'b0;
      cyc(2);
      chk(chip_reset_req, 1'b0);
      service_write <= 1'b1;
      service_window_open <= 1'b0;
      cyc(1);
      service_write <= 1'b0;
      cyc(2);
      chk(chip_reset_req, 1'b1);
   endtask
   initial begin
      do_reset();
      rchk(OFS_OPTIONS_ONE, 32'hc0);
      rchk(OFS_POWER_CTRL_ONE, 32'h1c);
      s_opts();
      s_id();
      s_warn();
      s_detect();
      s_window();
      summarize();
   end
endmodule

// File: design/sysopt_pkg.sv
package sysopt_pkg;

   // Byte addresses of the registers on the APB
   localparam logic [7:0] OFS_OPTIONS_ONE = 8'h00;
   localparam logic [7:0] OFS_OPTIONS_TWO = 8'h04;
   localparam logic [7:0] OFS_PART_ID_HIGH = 8'h08;
   localparam logic [7:0] OFS_PART_ID_LOW = 8'h0c;
   localparam logic [7:0] OFS_POWER_CTRL_ONE = 8'h10;

   // Field positions, options one
   localparam int TIMEOUT_SEL_LSB = 6;

   // Field positions, options two
   localparam int POS_CLOCK_SELECT = 7;
   localparam int POS_WINDOW_MODE = 6;
   localparam int POS_CMP_ROUTE = 4;
   localparam int POS_B_CH1 = 3;
   localparam int POS_B_CH0 = 2;
   localparam int POS_A_CH1 = 1;
   localparam int POS_A_CH0 = 0;

   // Field positions, power monitor control one
   localparam int POS_WARN_FLAG = 7;
   localparam int POS_WARN_ACK = 6;
   localparam int POS_WARN_IE = 5;
   localparam int POS_DET_RESET = 4;
   localparam int POS_DET_STOP = 3;
   localparam int POS_DET_EN = 2;
   localparam int POS_BANDGAP = 0;

   // Field positions, part id high
   localparam int POS_FAMILY_BIT = 7;
   localparam int PART_ID_HI_W = 4;

   // Values after reset
   localparam logic [1:0] RST_TIMEOUT_SEL = 2'h3;
   localparam logic [7:0] RST_OPTIONS_TWO = 8'h00;
   localparam logic RST_DET_RESET = 1'b1;
   localparam logic RST_DET_STOP = 1'b1;
   localparam logic RST_DET_EN = 1'b1;
   localparam logic RST_WARN_IE = 1'b0;
   localparam logic RST_BANDGAP = 1'b0;

   // Wait cycles in the access phase; the slave never waits
   localparam int APB_WAIT_CYCLES = 0;

   typedef struct packed {
      logic clock_select;
      logic window_mode;
      logic cmp_route;
      logic b_ch1;
      logic b_ch0;
      logic a_ch1;
      logic a_ch0;
   } options_two_t;

   typedef struct packed {
      logic warn_ie;
      logic det_reset;
      logic det_stop;
      logic det_en;
      logic bandgap;
   } power_ctrl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage

// File: design/system_options_power_monitor_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Clock select: 0 slow oscillator, 1 bus clock
// - Service sequence only in final timeout quarter
// - Early service write in window mode resets chip
// - Window mode works only with bus clock
// - Route bit feeds comparator to capture channel
// - Four bits pick default or alternate pins
// - Write-once bits take first write only
// - Part id high top bit reads zero
// - Part id high bits 6:4 ignore writes
// - Fixed read-only part number in id registers
// - Warning flag sticky until acknowledged
// - Flag sets below trip, also after reset
// - Acknowledge clears flag only if warning gone
// - Interrupt requested while flag and enable set
// - Detect reset enable resets chip on detect
// - Detect stays on in stop if enabled
// - Detect enable gates detect logic and options
// - Bandgap buffer enable drives reference buffer
// - Timeout from timeout select and clock select
module system_options_power_monitor_regs #(
   parameter logic [11:0] PART_NUMBER = 12'h5c3 // Arbitrary neutral value
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire sysopt_pkg::apb_req_t apb_req,
   output sysopt_pkg::apb_rsp_t apb_rsp,
   input wire logic supply_below_warning,
   input wire logic supply_below_detect,
   input wire logic stop_mode,
   input wire logic service_write,
   input wire logic service_window_open,
   input wire logic analog_comparator_out,
   input wire logic timer_a_ch0_pin_in,
   output logic timer_a_ch0_capture_in,
   output sysopt_pkg::options_two_t options_two,
   output logic [2:0] watchdog_timeout_code,
   output logic watchdog_window_active,
   output logic supply_detect_active,
   output logic bandgap_buffer_enable,
   output logic supply_warning_irq,
   output logic chip_reset_req
);
   import sysopt_pkg::*;

   // Zero would look like an unprogrammed part to a tool
   if (PART_NUMBER == 12'h000) begin : g_bad_part_number
      $error("PART_NUMBER must not be zero");
   end

   logic [1:0] timeout_sel_r;
   options_two_t opt2_r;
   power_ctrl_t pwr_r;
   logic warn_flag_r;
   logic lock_one_r;
   logic lock_two_r;
   logic lock_pwr_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic reset_req_r;

   // Two-stage synchronisers for the analog and pin inputs
   logic [1:0] warn_sync_r;
   logic [1:0] det_sync_r;
   logic [1:0] cmp_sync_r;
   logic [1:0] pin_sync_r;
   logic warn_s;
   logic det_s;
   logic cmp_s;
   logic pin_s;

   logic setup_phase;
   logic wr_access;
   logic wr_one;
   logic wr_two;
   logic wr_pwr;
   logic [7:0] wbyte;

   function automatic logic addr_mapped(input logic [7:0] a);
      begin
         addr_mapped = (a == OFS_OPTIONS_ONE) || (a == OFS_OPTIONS_TWO) ||
            (a == OFS_PART_ID_HIGH) || (a == OFS_PART_ID_LOW) ||
            (a == OFS_POWER_CTRL_ONE);
      end
   endfunction

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         warn_sync_r <= 2'h0;
         det_sync_r <= 2'h0;
         cmp_sync_r <= 2'h0;
         pin_sync_r <= 2'h0;
      end else begin
         warn_sync_r <= {warn_sync_r[0], supply_below_warning};
         det_sync_r <= {det_sync_r[0], supply_below_detect};
         cmp_sync_r <= {cmp_sync_r[0], analog_comparator_out};
         pin_sync_r <= {pin_sync_r[0], timer_a_ch0_pin_in};
      end
   end

   assign warn_s = warn_sync_r[1];
   assign det_s = det_sync_r[1];
   assign cmp_s = cmp_sync_r[1];
   assign pin_s = pin_sync_r[1];

   assign setup_phase = apb_req.psel && !apb_req.penable;
   assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign wr_one = wr_access && (apb_req.paddr == OFS_OPTIONS_ONE);
   assign wr_two = wr_access && (apb_req.paddr == OFS_OPTIONS_TWO);
   assign wr_pwr = wr_access && (apb_req.paddr == OFS_POWER_CTRL_ONE);
   assign wbyte = apb_req.pwdata[7:0];

   // Locks cleared only by reset, so a stray later write cannot undo setup
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lock_one_r <= 1'b0;
         lock_two_r <= 1'b0;
         lock_pwr_r <= 1'b0;
      end else begin
         if (wr_one) begin
            lock_one_r <= 1'b1;
         end
         if (wr_two) begin
            lock_two_r <= 1'b1;
         end
         if (wr_pwr) begin
            lock_pwr_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timeout_sel_r <= RST_TIMEOUT_SEL;
      end else if (wr_one && !lock_one_r) begin
         timeout_sel_r <= wbyte[TIMEOUT_SEL_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         opt2_r.clock_select <= RST_OPTIONS_TWO[POS_CLOCK_SELECT];
         opt2_r.window_mode <= RST_OPTIONS_TWO[POS_WINDOW_MODE];
         opt2_r.cmp_route <= RST_OPTIONS_TWO[POS_CMP_ROUTE];
         opt2_r.b_ch1 <= RST_OPTIONS_TWO[POS_B_CH1];
         opt2_r.b_ch0 <= RST_OPTIONS_TWO[POS_B_CH0];
         opt2_r.a_ch1 <= RST_OPTIONS_TWO[POS_A_CH1];
         opt2_r.a_ch0 <= RST_OPTIONS_TWO[POS_A_CH0];
      end else if (wr_two) begin
         if (!lock_two_r) begin
            opt2_r.clock_select <= wbyte[POS_CLOCK_SELECT];
            opt2_r.window_mode <= wbyte[POS_WINDOW_MODE];
         end
         opt2_r.cmp_route <= wbyte[POS_CMP_ROUTE];
         opt2_r.b_ch1 <= wbyte[POS_B_CH1];
         opt2_r.b_ch0 <= wbyte[POS_B_CH0];
         opt2_r.a_ch1 <= wbyte[POS_A_CH1];
         opt2_r.a_ch0 <= wbyte[POS_A_CH0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pwr_r.warn_ie <= RST_WARN_IE;
         pwr_r.det_reset <= RST_DET_RESET;
         pwr_r.det_stop <= RST_DET_STOP;
         pwr_r.det_en <= RST_DET_EN;
         pwr_r.bandgap <= RST_BANDGAP;
      end else if (wr_pwr) begin
         if (!lock_pwr_r) begin
            pwr_r.det_reset <= wbyte[POS_DET_RESET];
            pwr_r.det_stop <= wbyte[POS_DET_STOP];
            pwr_r.det_en <= wbyte[POS_DET_EN];
         end
         pwr_r.warn_ie <= wbyte[POS_WARN_IE];
         pwr_r.bandgap <= wbyte[POS_BANDGAP];
      end
   end

   // Set beats acknowledge: a present warning always keeps the flag up
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         warn_flag_r <= 1'b0;
      end else if (warn_s) begin
         warn_flag_r <= 1'b1;
      end else if (wr_pwr && wbyte[POS_WARN_ACK]) begin
         warn_flag_r <= 1'b0;
      end
   end

   assign supply_warning_irq = warn_flag_r && pwr_r.warn_ie;

   assign options_two = opt2_r;
   assign watchdog_timeout_code = {opt2_r.clock_select, timeout_sel_r};
   assign watchdog_window_active = opt2_r.window_mode && opt2_r.clock_select;
   assign bandgap_buffer_enable = pwr_r.bandgap;
   assign supply_detect_active = pwr_r.det_en && (!stop_mode || pwr_r.det_stop);

   // Comparator output already synchronised, like the pin, to avoid a glitching capture
   assign timer_a_ch0_capture_in = opt2_r.cmp_route ? cmp_s : pin_s;

   // Held until reset, which clears it; the reset controller acts on the level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reset_req_r <= 1'b0;
      end else if (watchdog_window_active && service_write && !service_window_open) begin
         reset_req_r <= 1'b1;
      end else if (supply_detect_active && pwr_r.det_reset && det_s) begin
         reset_req_r <= 1'b1;
      end
   end

   assign chip_reset_req = reset_req_r;

   // Read data captured in setup so it comes from a flop in the access phase
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup_phase) begin
         pslverr_r <= !addr_mapped(apb_req.paddr);
         prdata_r <= 32'h0000_0000;
         if (!apb_req.pwrite) begin
            case (apb_req.paddr)
               OFS_OPTIONS_ONE: begin
                  prdata_r[TIMEOUT_SEL_LSB +: 2] <= timeout_sel_r;
               end
               OFS_OPTIONS_TWO: begin
                  prdata_r[POS_CLOCK_SELECT] <= opt2_r.clock_select;
                  prdata_r[POS_WINDOW_MODE] <= opt2_r.window_mode;
                  prdata_r[POS_CMP_ROUTE] <= opt2_r.cmp_route;
                  prdata_r[POS_B_CH1] <= opt2_r.b_ch1;
                  prdata_r[POS_B_CH0] <= opt2_r.b_ch0;
                  prdata_r[POS_A_CH1] <= opt2_r.a_ch1;
                  prdata_r[POS_A_CH0] <= opt2_r.a_ch0;
               end
               OFS_PART_ID_HIGH: begin
                  prdata_r[POS_FAMILY_BIT] <= 1'b0;
                  prdata_r[PART_ID_HI_W-1:0] <= PART_NUMBER[11:8];
               end
               OFS_PART_ID_LOW: begin
                  prdata_r[7:0] <= PART_NUMBER[7:0];
               end
               OFS_POWER_CTRL_ONE: begin
                  prdata_r[POS_WARN_FLAG] <= warn_flag_r;
                  prdata_r[POS_WARN_IE] <= pwr_r.warn_ie;
                  prdata_r[POS_DET_RESET] <= pwr_r.det_reset;
                  prdata_r[POS_DET_STOP] <= pwr_r.det_stop;
                  prdata_r[POS_DET_EN] <= pwr_r.det_en;
                  prdata_r[POS_BANDGAP] <= pwr_r.bandgap;
               end
               default: begin
                  prdata_r <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // No wait states; id registers simply ignore writes
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = pslverr_r && apb_req.psel && apb_req.penable;
   assign apb_rsp.prdata = prdata_r;

endmodule
